// File: bench/scc_host.sv
// host station model: sends command frames and listens for readback frames
`timescale 1ns/1ps
`default_nettype none
module scc_host (
    input  wire logic clock,
    input  wire logic line,
    output logic      host_out,
    output logic      host_oe_n
);
    int bt = 16;
    initial begin
        host_out  = 1'b1;
        host_oe_n = 1'b1;
    end
    // start, eight bits lsb first, stop; low nibble is the location
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clock);
            host_oe_n <= 1'b0;
            host_out  <= f[i];
            repeat (bt - 1) @(posedge clock);
        end
        @(posedge clock);
        host_oe_n <= 1'b1;
    endtask
    // stays released throughout; samples mid bit so edge races cannot bite
    task automatic recv(output logic [7:0] b, output logic ok);
        int n;
        n = 0;
        b = 8'h00;
        ok = 1'b0;
        while (line !== 1'b0 && n < 40 * bt) begin
            @(posedge clock);
            n++;
        end
        if (n < 40 * bt) begin
            repeat (bt + bt / 2) @(posedge clock);
            for (int i = 0; i < 8; i++) begin
                b[i] = line;
                repeat (bt) @(posedge clock);
            end
            ok = line;
        end
    endtask
endmodule
`default_nettype wire

// File: bench/tb_scc_decoder.sv
// self-checking bench for the command decoder
`timescale 1ns/1ps
`default_nettype none
module tb_scc_decoder;
    import scc_pkg::*;
    logic               clock = 1'b0;
    logic               rst_n = 1'b0;
    logic [2:0]         osc_trim = 3'h0;
    logic [15:0]        cal_rdata = 16'h0000;
    logic [7:0]         temp_index = 8'h5A;
    logic               serial_out, serial_oe_n, analog_on, host_out, host_oe_n;
    logic signed [7:0]  osc_adjust_pct;
    logic [3:0]         analog_sel;
    logic [7:0]         bit_time_count;
    scc_cal_req_t       cal_req, ld;
    int                 err_count = 0, tests_run = 0, loads = 0, seed = 32'h7781;
    int                 data_hold_register = 0, rs[16], n, a;
    // pull-up wins when nobody drives
    wire logic line = !serial_oe_n ? serial_out : (!host_oe_n ? host_out : 1'b1);
    always #2 clock = ~clock;
    scc_decoder dut (.clock(clock), .rst_n(rst_n), .serial_in(line),
        .serial_out(serial_out), .serial_oe_n(serial_oe_n), .osc_trim(osc_trim),
        .osc_adjust_pct(osc_adjust_pct), .cal_req(cal_req), .cal_rdata(cal_rdata),
        .temp_index(temp_index), .analog_on(analog_on), .analog_sel(analog_sel),
        .bit_time_count(bit_time_count));
    scc_host host (.clock(clock), .line(line), .host_out(host_out), .host_oe_n(host_oe_n));
    always @(posedge clock) begin
        if (cal_req.load === 1'b1) begin
            loads++;
            ld = cal_req;
        end
    end
    task automatic conclude();
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] loc, input logic [3:0] d);
        host.send({d, loc});
        if (loc < 4'h4)
            data_hold_register[loc * 4 +: 4] = d;
        else if (loc inside {[6:11]})
            rs[loc] = d;
    endtask
    function automatic logic [7:0] exp_rb(input int p);
        case (p)
            0: return data_hold_register[7:0];
            1: return data_hold_register[15:8];
            2, 5: return {rs[7][3:0], rs[6][3:0]};
            3: return {rs[9][3:0], rs[8][3:0]};
            4: return {rs[11][3:0], rs[10][3:0]};
            7: return temp_index;
            8: return host.bt[7:0];
            9: return 8'h00;
            default: return 8'hCA;
        endcase
    endfunction
    // waits out the answer and the guard byte before the next frame
    task automatic guard();
        n = 0;
        while (serial_oe_n !== 1'b1 || analog_on !== 1'b0) begin
            @(posedge clock);
            n++;
            if (n > 4000) begin
                err_count++;
                conclude();
            end
        end
        repeat (12 * host.bt) @(posedge clock);
    endtask
    task automatic rdb(input int p);
        logic [7:0] v;
        logic       ok;
        wr(4'h8, p[3:0]);
        wr(4'h9, 4'h5);
        host.recv(v, ok);
        chk("readback", {exp_rb(p), 8'h01}, {v, 7'h00, ok});
        guard();
    endtask
    task automatic rom(input logic [3:0] c);
        wr(4'h6, rs[6][3:0]);
        wr(4'h7, rs[7][3:0]);
        wr(4'h8, 4'(a));
        wr(4'h9, c);
    endtask
    initial begin
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        repeat (6) @(posedge clock);
        host.send(8'h01);
        repeat (4) @(posedge clock);
        chk("bit time", 16'h0010, {8'h00, bit_time_count});
        for (int t = 0; t < 8; t++) begin
            osc_trim <= t[2:0];
            repeat (3) @(posedge clock);
            chk("trim", 16'($signed(t[2:0]) * 9), 16'(osc_adjust_pct));
        end
        host.send(8'hFF);
        host.bt = 20;
        host.send(8'h01);
        repeat (4) @(posedge clock);
        chk("relearn", 16'h0014, {8'h00, bit_time_count});
        for (int k = 0; k < 16; k++)
            if (k != 9)
                wr(k[3:0], (k == 15) ? 4'h3 : 4'($random(seed)));
        for (int p = 0; p < 16; p++)
            if (p != 6)
                rdb(p);
        n = loads;
        wr(4'h9, 4'h0);
        repeat (4) @(posedge clock);
        chk("cal load", 16'h0001, 16'(loads - n));
        chk("cal data", data_hold_register[15:0], ld.wdata);
        chk("cal index", 16'(rs[6]), {12'h000, ld.index});
        for (int c = 8; c < 16; c++)
            wr(4'h9, c[3:0]);
        chk("no load", 16'(n + 1), 16'(loads));
        rdb(0);
        cal_rdata <= 16'($random(seed));
        wr(4'h9, 4'h3);
        data_hold_register = cal_rdata;
        rdb(1);
        a = 2;
        rom(4'h2);
        rom(4'h4);
        data_hold_register[7:0] = 8'hFF;
        rdb(0);
        wr(4'h0, 4'h5);
        wr(4'h1, 4'hA);
        rom(4'h1);
        wr(4'h0, 4'h0);
        rom(4'h4);
        data_hold_register[7:0] = 8'hA5;
        rdb(0);
        rom(4'h7);
        rom(4'h4);
        data_hold_register[7:0] = 8'hFF;
        rdb(0);
        wr(4'hA, 4'h2);
        wr(4'hB, 4'h9);
        wr(4'h9, 4'h6);
        n = 0;
        while (analog_on !== 1'b1 && n < 1000) begin
            @(posedge clock);
            n++;
        end
        chk("analog sel", 16'h0009, {12'h000, analog_sel});
        n = 0;
        while (analog_on === 1'b1 && n < 1000) begin
            @(posedge clock);
            n++;
        end
        chk("analog span", 16'(20 * host.bt), 16'(n));
        guard();
        conclude();
    end
endmodule
`default_nettype wire

// File: src/scc_decoder.sv
// single-wire command decoder: baud learning, location steering, commands
`include "scc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module scc_decoder #(
    parameter int ROM_DEPTH = 768,
    parameter int ROM_PAGE  = 64
) (
    input  wire logic                clock,
    input  wire logic                rst_n,
    input  wire logic                serial_in,
    output logic                     serial_out,
    output logic                     serial_oe_n,
    input  wire logic [2:0]          osc_trim,
    output logic signed [7:0]        osc_adjust_pct,
    output scc_pkg::scc_cal_req_t    cal_req,
    input  wire logic [15:0]         cal_rdata,
    input  wire logic [7:0]          temp_index,
    output logic                     analog_on,
    output logic [3:0]               analog_sel,
    output logic [7:0]               bit_time_count
);
    import scc_pkg::*;

    scc_state_t   s_r;
    scc_state_t   s_nxt;
    scc_rom_req_t rom_req;
    logic [7:0]   rom_rdata;
    logic         tick;
    logic         byte_end;
    ////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [7:0] clamp_bt(input logic [8:0] c);
        if (c > {1'b0, `SCC_BT_MAX}) begin
            return `SCC_BT_MAX;
        end else if (c == '0) begin
            return 8'h01;
        end
        return c[7:0];
    endfunction
    function automatic logic [8:0] half_bt(input logic [7:0] b);
        return {2'b00, b[7:1]};
    endfunction
    function automatic logic signed [7:0] trim_pct(input logic [2:0] t);
        logic signed [7:0] ext;
        ext = $signed({{5{t[2]}}, t});
        return 8'(ext * `SCC_TRIM_STEP);
    endfunction
    // readback source table; pointer 9 is reserved and reads zero
    function automatic logic [7:0] rb_byte(input scc_state_t s,
                                           input logic [7:0] rom_d,
                                           input logic [7:0] tidx);
        if (s.ptr >= `SCC_PTR_CHECK_LO) begin
            return `SCC_CHECK_PATTERN;
        end
        unique case (s.ptr)
            4'h0:    return s.data_hold_register[7:0];
            4'h1:    return s.data_hold_register[15:8];
            4'h2:    return {s.amid, s.idx};
            4'h3:    return {`SCC_CMD_READBACK, s.ptr};
            4'h4:    return {s.analog_source_select, s.analog_timeout};
            4'h5:    return {s.amid, s.idx};
            4'h6:    return rom_d;
            4'h7:    return tidx;
            4'h8:    return s.btime;
            default: return 8'h00;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // byte store
    assign rom_req.write      = s_r.rom_we;
    assign rom_req.erase_all  = s_r.rom_erase;
    assign rom_req.erase_page = s_r.rom_page;
    assign rom_req.addr       = {s_r.ptr[1:0], s_r.amid, s_r.idx};
    assign rom_req.wdata      = s_r.data_hold_register[7:0];
    scc_rom #(
        .DEPTH     (ROM_DEPTH),
        .PAGE_SIZE (ROM_PAGE)
    ) u_rom (
        .clock (clock),
        .req   (rom_req),
        .rdata (rom_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state
    assign tick     = (s_r.oc == '0);
    assign byte_end = tick && (s_r.obits == `SCC_LAST_BYTE_BIT);

    always_comb begin
        s_nxt           = s_r;
        s_nxt.done      = 1'b0;
        s_nxt.cal_load  = 1'b0;
        s_nxt.rom_we    = 1'b0;
        s_nxt.rom_erase = 1'b0;
        s_nxt.rom_page  = 1'b0;
        s_nxt.adj       = trim_pct(osc_trim);
        // first stage feeds only the second
        s_nxt.s1 = serial_in;
        s_nxt.s2 = s_r.s1;
        s_nxt.s3 = s_r.s2;
        if (s_r.s2 == s_r.s3) begin
            s_nxt.line = s_r.s3;
        end

        // receiver; the learn byte's start bit sets the bit time
        unique case (s_r.rx)
            RX_LEARN_WAIT: begin
                if (!s_r.line) begin
                    s_nxt.rx = RX_LEARN_LOW;
                    s_nxt.rc = 9'h001; // entry edge already saw one low clock
                end
            end
            RX_LEARN_LOW: begin
                if (s_r.line) begin
                    // saturates: very slow links cannot be learned
                    s_nxt.btime   = clamp_bt(s_r.rc);
                    s_nxt.rc      = half_bt(clamp_bt(s_r.rc));
                    s_nxt.rbits   = '0;
                    s_nxt.discard = 1'b1;
                    s_nxt.rx      = RX_DATA;
                end else if (s_r.rc != `SCC_RC_MAX) begin
                    s_nxt.rc = s_r.rc + 9'h001;
                end
            end
            RX_IDLE: begin
                // the line is ignored while an answer or readout runs
                if (!s_r.line && s_r.out == OUT_IDLE) begin
                    s_nxt.rc      = {1'b0, s_r.btime} + half_bt(s_r.btime);
                    s_nxt.rbits   = '0;
                    s_nxt.discard = 1'b0;
                    s_nxt.rx      = RX_DATA;
                end
            end
            RX_DATA: begin
                if (s_r.rc == '0) begin
                    s_nxt.rsh   = {s_r.line, s_r.rsh[7:1]};
                    s_nxt.rc    = {1'b0, s_r.btime - 8'h01};
                    s_nxt.rbits = s_r.rbits + 4'h1;
                    if (s_r.rbits == `SCC_LAST_DATA_BIT) begin
                        s_nxt.rx = RX_STOP;
                    end
                end else begin
                    s_nxt.rc = s_r.rc - 9'h001;
                end
            end
            RX_STOP: begin
                if (s_r.rc == '0) begin
                    s_nxt.rx = RX_IDLE;
                    if (!s_r.discard) begin
                        s_nxt.done  = 1'b1;
                        s_nxt.rbyte = s_r.rsh;
                    end
                end else begin
                    s_nxt.rc = s_r.rc - 9'h001;
                end
            end
        endcase

        // location steering: low nibble picks, high nibble is data
        if (s_r.done) begin
            unique case (s_r.rbyte[3:0])
                `SCC_LOC_HOLD0:    s_nxt.data_hold_register[3:0]   = s_r.rbyte[7:4];
                `SCC_LOC_HOLD1:    s_nxt.data_hold_register[7:4]   = s_r.rbyte[7:4];
                `SCC_LOC_HOLD2:    s_nxt.data_hold_register[11:8]  = s_r.rbyte[7:4];
                `SCC_LOC_HOLD3:    s_nxt.data_hold_register[15:12] = s_r.rbyte[7:4];
                `SCC_LOC_INDEX:    s_nxt.idx  = s_r.rbyte[7:4];
                `SCC_LOC_ADDR_MID: s_nxt.amid = s_r.rbyte[7:4];
                `SCC_LOC_POINTER:  s_nxt.ptr  = s_r.rbyte[7:4];
                `SCC_LOC_TIMEOUT:  s_nxt.analog_timeout = s_r.rbyte[7:4];
                `SCC_LOC_SOURCE:   s_nxt.analog_source_select = s_r.rbyte[7:4];
                `SCC_LOC_RELEARN: begin
                    if (s_r.rbyte[7:4] == `SCC_RELEARN_DATA) begin
                        s_nxt.rx = RX_LEARN_WAIT;
                    end
                end
                `SCC_LOC_COMMAND: begin
                    s_nxt.cmd = s_r.rbyte[7:4];
                    unique case (s_r.rbyte[7:4])
                        `SCC_CMD_LOAD_CAL:  s_nxt.cal_load  = 1'b1;
                        `SCC_CMD_ROM_WRITE: s_nxt.rom_we    = 1'b1;
                        `SCC_CMD_ROM_ERASE: s_nxt.rom_erase = 1'b1;
                        `SCC_CMD_READ_CAL:  s_nxt.data_hold_register = cal_rdata;
                        `SCC_CMD_ROM_READ:  s_nxt.data_hold_register[7:0] = rom_rdata;
                        `SCC_CMD_PAGE_WIPE: s_nxt.rom_page  = 1'b1;
                        `SCC_CMD_READBACK: begin
                            // sent LSB first: idle high, start, data, stop
                            s_nxt.osh = {1'b1, rb_byte(s_r, rom_rdata, temp_index),
                                         2'b01};
                            s_nxt.amode = 1'b0;
                            s_nxt.out   = OUT_LEAD;
                            s_nxt.oc    = {1'b0, s_r.btime - 8'h01};
                            s_nxt.obits = '0;
                        end
                        `SCC_CMD_ANALOG: begin
                            s_nxt.amode = 1'b1;
                            s_nxt.out   = OUT_LEAD;
                            s_nxt.oc    = {1'b0, s_r.btime - 8'h01};
                            s_nxt.obits = '0;
                        end
                        default: ;
                    endcase
                end
                default: ;
            endcase
        end

        // answer and readout timing in bit and byte times
        if (s_r.out != OUT_IDLE) begin
            if (tick) begin
                s_nxt.oc    = {1'b0, s_r.btime - 8'h01};
                s_nxt.obits = byte_end ? 4'h0 : s_r.obits + 4'h1;
            end else begin
                s_nxt.oc = s_r.oc - 9'h001;
            end
        end
        unique case (s_r.out)
            OUT_IDLE: ;
            OUT_LEAD: begin
                if (byte_end && s_r.amode) begin
                    if (s_r.analog_timeout == '0) begin
                        s_nxt.out = OUT_GUARD;
                    end else begin
                        s_nxt.out       = OUT_ANALOG;
                        s_nxt.analog_on = 1'b1;
                        s_nxt.obytes    = (s_r.analog_timeout == `SCC_TIMEOUT_CONT) ?
                                          `SCC_CONT_BYTES - 16'h0001 :
                                          {12'h000, s_r.analog_timeout} - 16'h0001;
                    end
                end else if (byte_end) begin
                    s_nxt.out    = OUT_SEND;
                    s_nxt.oe_n   = 1'b0;
                    s_nxt.line_o = s_r.osh[0];
                    s_nxt.osh    = {1'b1, s_r.osh[10:1]};
                end
            end
            OUT_SEND: begin
                if (tick && s_r.obits == `SCC_LAST_TX_BIT) begin
                    s_nxt.oe_n   = 1'b1;
                    s_nxt.line_o = 1'b1;
                    s_nxt.obits  = '0;
                    s_nxt.out    = OUT_GUARD;
                end else if (tick) begin
                    s_nxt.obits  = s_r.obits + 4'h1;
                    s_nxt.line_o = s_r.osh[0];
                    s_nxt.osh    = {1'b1, s_r.osh[10:1]};
                end
            end
            OUT_ANALOG: begin
                if (byte_end) begin
                    if (s_r.obytes == '0) begin
                        s_nxt.analog_on = 1'b0;
                        s_nxt.out       = OUT_GUARD;
                    end else begin
                        s_nxt.obytes = s_r.obytes - 16'h0001;
                    end
                end
            end
            OUT_GUARD: begin
                if (byte_end) begin
                    s_nxt.out = OUT_IDLE;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_r        <= '0;
            s_r.s1     <= 1'b1;
            s_r.s2     <= 1'b1;
            s_r.s3     <= 1'b1;
            s_r.line   <= 1'b1;
            s_r.rx     <= RX_LEARN_WAIT;
            s_r.out    <= OUT_IDLE;
            s_r.btime  <= `SCC_BT_MAX;
            s_r.line_o <= 1'b1;
            s_r.oe_n   <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign serial_out     = s_r.line_o;
    assign serial_oe_n    = s_r.oe_n;
    assign osc_adjust_pct = s_r.adj;
    assign cal_req.load   = s_r.cal_load;
    assign cal_req.index  = s_r.idx;
    assign cal_req.wdata  = s_r.data_hold_register;
    assign analog_on      = s_r.analog_on;
    assign analog_sel     = s_r.analog_source_select;
    assign bit_time_count = s_r.btime;

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_hold_low_nibble: assert property (@(posedge clock) disable iff (!rst_n)
        s_r.done && s_r.rbyte[3:0] == `SCC_LOC_HOLD0
        |=> s_r.data_hold_register[3:0] == $past(s_r.rbyte[7:4]) && $stable(s_r.data_hold_register[15:4]))
        else $error("hold nibble 0 not loaded");
    a_index_load: assert property (@(posedge clock) disable iff (!rst_n)
        s_r.done && s_r.rbyte[3:0] == `SCC_LOC_INDEX
        |=> s_r.idx == $past(s_r.rbyte[7:4]) && $stable(s_r.amid))
        else $error("index nibble not loaded");
    a_pointer_addr: assert property (@(posedge clock) disable iff (!rst_n)
        s_r.done && s_r.rbyte[3:0] == `SCC_LOC_POINTER
        |=> s_r.ptr == $past(s_r.rbyte[7:4])
            && rom_req.addr[9:8] == $past(s_r.rbyte[5:4]))
        else $error("pointer low bits not on address");
    a_load_cal_pulse: assert property (@(posedge clock) disable iff (!rst_n)
        s_r.done && s_r.rbyte == {`SCC_CMD_LOAD_CAL, `SCC_LOC_COMMAND}
        |=> cal_req.load ##1 !cal_req.load)
        else $error("calibration load not a single pulse");
    a_erase_pulse: assert property (@(posedge clock) disable iff (!rst_n)
        s_r.done && s_r.rbyte == {`SCC_CMD_ROM_ERASE, `SCC_LOC_COMMAND}
        |=> rom_req.erase_all && !rom_req.write)
        else $error("erase not issued");
    a_relearn_reset: assert property (@(posedge clock) disable iff (!rst_n)
        s_r.done && s_r.rbyte == {`SCC_RELEARN_DATA, `SCC_LOC_RELEARN}
        |=> s_r.rx == RX_LEARN_WAIT)
        else $error("relearn not entered");
    a_reserved_quiet: assert property (@(posedge clock) disable iff (!rst_n)
        s_r.done && s_r.rbyte[7] && s_r.rbyte[3:0] == `SCC_LOC_COMMAND
        |=> !cal_req.load && !rom_req.write && !rom_req.erase_all
            && $stable(s_r.data_hold_register) && s_r.out == OUT_IDLE)
        else $error("reserved command acted");
    a_check_pattern: assert property (@(posedge clock) disable iff (!rst_n)
        s_r.done && s_r.rbyte == {`SCC_CMD_READBACK, `SCC_LOC_COMMAND}
        && s_r.ptr >= `SCC_PTR_CHECK_LO
        |=> s_r.osh[9:2] == `SCC_CHECK_PATTERN)
        else $error("check pattern not queued");
    a_line_released: assert property (@(posedge clock) disable iff (!rst_n)
        s_r.out != OUT_SEND |-> serial_oe_n)
        else $error("line driven outside a frame");
    a_trim_scale: assert property (@(posedge clock) disable iff (!rst_n)
        $past(osc_trim) == 3'b111 |-> osc_adjust_pct == -8'sd9)
        else $error("trim scaling wrong");
endmodule
`default_nettype wire

// File: src/scc_pkg.sv
// types shared by the command decoder and its byte store
package scc_pkg;

    typedef enum logic [2:0] {
        RX_LEARN_WAIT,
        RX_LEARN_LOW,
        RX_IDLE,
        RX_DATA,
        RX_STOP
    } scc_rx_t;

    typedef enum logic [2:0] {
        OUT_IDLE,
        OUT_LEAD,
        OUT_SEND,
        OUT_ANALOG,
        OUT_GUARD
    } scc_out_t;

    typedef struct packed {
        logic        load;
        logic [3:0]  index;
        logic [15:0] wdata;
    } scc_cal_req_t;

    typedef struct packed {
        logic       write;
        logic       erase_all;
        logic       erase_page;
        logic [9:0] addr;
        logic [7:0] wdata;
    } scc_rom_req_t;

    typedef struct packed {
        logic        s1, s2, s3, line;
        scc_rx_t     rx;
        logic [8:0]  rc;
        logic [3:0]  rbits;
        logic [7:0]  rsh;
        logic        discard;
        logic        done;
        logic [7:0]  rbyte;
        logic [15:0] data_hold_register;
        logic [3:0]  idx, amid, ptr, cmd, analog_timeout, analog_source_select;
        logic [7:0]  btime;
        scc_out_t    out;
        logic        amode;
        logic [8:0]  oc;
        logic [3:0]  obits;
        logic [15:0] obytes;
        logic [10:0] osh;
        logic        line_o, oe_n, analog_on;
        logic        cal_load, rom_we, rom_erase, rom_page;
        logic [7:0]  adj;
    } scc_state_t;

endpackage

// File: src/scc_regs.svh
// location, command and timing constants for the command decoder
`ifndef SCC_REGS_SVH
`define SCC_REGS_SVH

`define SCC_LOC_HOLD0    4'h0
`define SCC_LOC_HOLD1    4'h1
`define SCC_LOC_HOLD2    4'h2
`define SCC_LOC_HOLD3    4'h3
`define SCC_LOC_INDEX    4'h6
`define SCC_LOC_ADDR_MID 4'h7
`define SCC_LOC_POINTER  4'h8
`define SCC_LOC_COMMAND  4'h9
`define SCC_LOC_TIMEOUT  4'hA
`define SCC_LOC_SOURCE   4'hB
`define SCC_LOC_RELEARN  4'hF
`define SCC_RELEARN_DATA 4'hF

`define SCC_CMD_LOAD_CAL  4'h0
`define SCC_CMD_ROM_WRITE 4'h1
`define SCC_CMD_ROM_ERASE 4'h2
`define SCC_CMD_READ_CAL  4'h3
`define SCC_CMD_ROM_READ  4'h4
`define SCC_CMD_READBACK  4'h5
`define SCC_CMD_ANALOG    4'h6
`define SCC_CMD_PAGE_WIPE 4'h7

`define SCC_CHECK_PATTERN 8'hCA
`define SCC_PTR_CHECK_LO  4'hA
`define SCC_TIMEOUT_CONT  4'hF
`define SCC_CONT_BYTES    16'h8001
`define SCC_LAST_DATA_BIT 4'h7
`define SCC_LAST_BYTE_BIT 4'h9
`define SCC_LAST_TX_BIT   4'hA
`define SCC_RC_MAX        9'h1FF
`define SCC_BT_MAX        8'hFF
`define SCC_TRIM_STEP     8'sh09
`define SCC_ROM_ERASED    8'hFF

`endif

// File: src/scc_rom.sv
// byte store for the non-volatile array with whole and page erase
`timescale 1ns/1ps
`default_nettype none
`include "scc_regs.svh"
module scc_rom #(
    parameter int DEPTH     = 768,
    parameter int PAGE_SIZE = 64
) (
    input  wire logic              clock,
    input  wire scc_pkg::scc_rom_req_t req,
    output logic [7:0]             rdata
);
    import scc_pkg::*;

    logic [7:0] mem [DEPTH];

    // erase wins over a write in the same cycle
    always_ff @(posedge clock) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (req.erase_all) begin
                mem[i] <= `SCC_ROM_ERASED;
            end else if (req.erase_page && (i / PAGE_SIZE) == int'(req.addr[9:6])) begin
                mem[i] <= `SCC_ROM_ERASED;
            end else if (req.write && i == int'(req.addr)) begin
                mem[i] <= req.wdata;
            end
        end
        // addresses past the array read as erased
        if (int'(req.addr) < DEPTH) begin
            rdata <= mem[req.addr];
        end else begin
            rdata <= `SCC_ROM_ERASED;
        end
    end
endmodule
`default_nettype wire
